// ===== verilog/dsl_pkg.sv
package dsl_pkg;
	localparam int OPCODE_W = 8;
	localparam int WORD_W   = 16;
	localparam int PW_BITS  = 256;
	localparam int PW_WORDS = 16;
	localparam int CNT_W    = 3;

	localparam logic [7:0] OP_SET_PW     = 8'hF1;
	localparam logic [7:0] OP_UNLOCK     = 8'hF2;
	localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
	localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
	localparam logic [7:0] OP_FREEZE     = 8'hF5;
	localparam logic [7:0] OP_DISABLE_PW = 8'hF6;

	localparam logic [7:0] WORD_CTL      = 8'h00;
	localparam logic [7:0] WORD_PW_FIRST = 8'h01;
	localparam logic [7:0] WORD_PW_LAST  = 8'h10;
	localparam logic [7:0] WORD_REV      = 8'h11;
	localparam logic [7:0] WORD_LAST     = 8'hFF;

	localparam int CTL_SLOT_BIT  = 0;
	localparam int CTL_LEVEL_BIT = 8;

	localparam int ERR_ABT_BIT = 2;
	localparam int ST_BSY_BIT  = 7;
	localparam int ST_RDY_BIT  = 6;
	localparam int ST_DSC_BIT  = 4;
	localparam int ST_DRQ_BIT  = 3;
	localparam int ST_ERR_BIT  = 0;

	localparam logic [2:0]  ATTEMPTS_INIT = 3'h5;
	localparam logic [15:0] REV_KEEP_LO   = 16'h0000;
	localparam logic [15:0] REV_KEEP_HI   = 16'hFFFF;
	localparam logic [15:0] REV_INIT      = 16'h0000;

	typedef enum logic [1:0] {CMD_IDLE, CMD_RECV, CMD_EXEC} dsl_cmd_state_type;
endpackage

// ===== verilog/dsl_sector_rx.sv
`timescale 1ns/100ps
module dsl_sector_rx (
	input  wire logic                         i_clk,
	input  wire logic                         i_rst,
	input  wire logic                         i_start,
	input  wire logic                         i_abort,
	input  wire logic                         i_wr,
	input  wire logic [dsl_pkg::WORD_W-1:0]   i_word,
	output logic      [dsl_pkg::WORD_W-1:0]   o_ctl,
	output logic      [dsl_pkg::PW_BITS-1:0]  o_pw,
	output logic      [dsl_pkg::WORD_W-1:0]   o_rev,
	output logic                              o_done
);
	import dsl_pkg::*;

	logic [WORD_W-1:0] pw_mem_reg  [PW_WORDS];
	logic [WORD_W-1:0] pw_mem_next [PW_WORDS];
	logic [7:0]        idx_reg, idx_next;
	logic              busy_reg, busy_next;
	logic              done_reg, done_next;
	logic [WORD_W-1:0] ctl_reg, ctl_next;
	logic [WORD_W-1:0] rev_reg, rev_next;

	// Words are counted only while a sector is expected; word 0 is control,
	// 1 to 16 the password, 17 the revision code, the rest is discarded.
	always_comb begin
		pw_mem_next = pw_mem_reg;
		idx_next    = idx_reg;
		busy_next   = busy_reg;
		ctl_next    = ctl_reg;
		rev_next    = rev_reg;
		done_next   = 1'b0;
		if (i_abort) begin
			busy_next = 1'b0;
		end else if (i_start) begin
			busy_next = 1'b1;
			idx_next  = 8'h00;
		end else if (busy_reg && i_wr) begin
			if (idx_reg == WORD_CTL) begin
				ctl_next = i_word;
			end
			if (idx_reg >= WORD_PW_FIRST && idx_reg <= WORD_PW_LAST) begin
				pw_mem_next[4'(idx_reg - WORD_PW_FIRST)] = i_word;
			end
			if (idx_reg == WORD_REV) begin
				rev_next = i_word;
			end
			idx_next = idx_reg + 8'h01;
			if (idx_reg == WORD_LAST) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pw_mem_reg <= '{default: 16'h0000};
			idx_reg    <= 8'h00;
			busy_reg   <= 1'b0;
			done_reg   <= 1'b0;
			ctl_reg    <= 16'h0000;
			rev_reg    <= 16'h0000;
		end else begin
			pw_mem_reg <= pw_mem_next;
			idx_reg    <= idx_next;
			busy_reg   <= busy_next;
			done_reg   <= done_next;
			ctl_reg    <= ctl_next;
			rev_reg    <= rev_next;
		end
	end

	always_comb begin
		for (int i = 0; i < PW_WORDS; i++) begin
			o_pw[i*WORD_W +: WORD_W] = pw_mem_reg[i];
		end
	end

	assign o_ctl  = ctl_reg;
	assign o_rev  = rev_reg;
	assign o_done = done_reg;
endmodule // dsl_sector_rx

// ===== verilog/dsl_lock_top.sv
`timescale 1ns/100ps
// Overview of operation
// (R1) Freeze opcode enters frozen state at once, with no sector transfer.
// (R2) While frozen, set password, unlock, disable and erase unit abort.
// (R3) Frozen survives hard and soft reset; only power loss clears it.
// (R4) Setting user password arms lock; device locks after next hard or power-on reset. Power-on reset (I_RST) here clears the arm instead.
// (R5) Setting master password stores it but never arms the lock.
// (R6) Set password and unlock take one 256-word sector: control, password, revision.
// (R7) Control bit 0 picks master slot, bit 8 picks maximum level.
// (R8) Passwords are stored and compared over all 32 bytes.
// (R9) Revision 0001h to FFFEh replaces stored code; 0000h and FFFFh keep it.
// (R10) High level: user or master password unlocks.
// (R11) Maximum level: only user password unlocks; master kept but refused.
// (R12) At maximum level only erase prepare plus erase unit clears lock without user.
// (R13) Good unlock clears locked state, keeps passwords; hard reset relocks if armed.
// (R14) Master unlock compares at high level, aborts at maximum level.
// (R15) User unlock compares against stored user password.
// (R16) Failed unlock aborts and decrements counter from five; at zero reject all. Here freeze and erase prepare are still accepted at zero.
// (R17) Abort after unlock sector means mismatch only; other faults abort earlier. Here a master unlock at maximum level also aborts after the sector.
// (R18) Hard or power-on reset restores attempt counter to five.
module dsl_lock_top (
	input  wire logic                          I_CLK,
	input  wire logic                          I_RST,
	input  wire logic                          I_HARD_RST_N,
	input  wire logic                          I_SOFT_RST,
	input  wire logic                          I_CMD_WR,
	input  wire logic [dsl_pkg::OPCODE_W-1:0]  I_CMD_OPCODE,
	input  wire logic                          I_DATA_WR,
	input  wire logic [dsl_pkg::WORD_W-1:0]    I_DATA,
	output logic      [7:0]                    O_ERROR,
	output logic      [7:0]                    O_STATUS,
	output logic      [dsl_pkg::WORD_W-1:0]    O_REV_CODE,
	output logic                               O_FROZEN,
	output logic                               O_LOCKED,
	output logic                               O_LOCK_ARMED,
	output logic                               O_LEVEL_MAX,
	output logic      [dsl_pkg::CNT_W-1:0]     O_ATTEMPTS,
	output logic                               O_ERASE_START
);
	import dsl_pkg::*;

	logic [2:0]         hr_sync_reg, hr_sync_next;
	logic               hr_active_reg, hr_active_next;
	dsl_cmd_state_type  state_reg, state_next;
	logic [7:0]         op_reg, op_next;
	logic               abt_reg, abt_next;
	logic               frozen_reg, frozen_next;
	logic               armed_reg, armed_next;
	logic               locked_reg, locked_next;
	logic               level_max_reg, level_max_next;
	logic               prepared_reg, prepared_next;
	logic               erase_reg, erase_next;
	logic [CNT_W-1:0]   attempts_reg, attempts_next;
	logic [WORD_W-1:0]  rev_reg, rev_next;
	logic [PW_BITS-1:0] user_pw_reg, user_pw_next;
	logic [PW_BITS-1:0] master_pw_reg, master_pw_next;
	logic [WORD_W-1:0]  rx_ctl;
	logic [PW_BITS-1:0] rx_pw;
	logic [WORD_W-1:0]  rx_rev;
	logic               rx_done;
	logic               rx_start;
	logic               take_ok;
	logic               master_sel;
	logic               master_refused;
	logic               pw_match;

	function automatic logic pw_cmd(input logic [7:0] op);
		return op == OP_SET_PW || op == OP_UNLOCK || op == OP_ERASE_UNIT || op == OP_DISABLE_PW;
	endfunction

	// (R8) full-width compare
	function automatic logic pw_equal(input logic [PW_BITS-1:0] a, input logic [PW_BITS-1:0] b);
		return a == b;
	endfunction

	dsl_sector_rx u_rx (
		.i_clk   (I_CLK),
		.i_rst   (I_RST),
		.i_start (rx_start),
		.i_abort (hr_active_reg || I_SOFT_RST),
		.i_wr    (I_DATA_WR),
		.i_word  (I_DATA),
		.o_ctl   (rx_ctl),
		.o_pw    (rx_pw),
		.o_rev   (rx_rev),
		.o_done  (rx_done)
	);

	// The hard reset pin counts once the second and third stages agree.
	always_comb begin
		hr_sync_next   = {hr_sync_reg[1:0], I_HARD_RST_N};
		hr_active_next = hr_active_reg;
		if (hr_sync_reg[1] == hr_sync_reg[2]) begin
			hr_active_next = ~hr_sync_reg[2];
		end
	end

	assign take_ok    = I_CMD_WR && state_reg == CMD_IDLE && !hr_active_reg && !I_SOFT_RST;
	// (R7) slot select bit
	assign master_sel = rx_ctl[CTL_SLOT_BIT];
	// (R14) master refused at maximum
	assign master_refused = master_sel && level_max_reg;
	// (R15) slot compare select
	assign pw_match = master_sel ? pw_equal(master_pw_reg, rx_pw) : pw_equal(user_pw_reg, rx_pw);

	always_comb begin
		state_next     = state_reg;
		op_next        = op_reg;
		abt_next       = abt_reg;
		frozen_next    = frozen_reg;
		armed_next     = armed_reg;
		locked_next    = locked_reg;
		level_max_next = level_max_reg;
		prepared_next  = prepared_reg;
		attempts_next  = attempts_reg;
		rev_next       = rev_reg;
		user_pw_next   = user_pw_reg;
		master_pw_next = master_pw_reg;
		erase_next     = 1'b0;
		rx_start       = 1'b0;
		if (hr_active_reg) begin
			// (R13) relock on hard reset; (R4) armed lock engages; (R18) counter back
			state_next    = CMD_IDLE;
			abt_next      = 1'b0;
			prepared_next = 1'b0;
			locked_next   = armed_reg;
			attempts_next = ATTEMPTS_INIT;
		end else if (I_SOFT_RST) begin
			// (R3) frozen left untouched
			state_next    = CMD_IDLE;
			abt_next      = 1'b0;
			prepared_next = 1'b0;
		end else begin
			unique case (state_reg)
				CMD_IDLE: begin
					if (I_CMD_WR) begin
						op_next       = I_CMD_OPCODE;
						abt_next      = 1'b0;
						prepared_next = I_CMD_OPCODE == OP_ERASE_PREP;
						if (I_CMD_OPCODE == OP_FREEZE) begin
							// (R1) frozen at once
							frozen_next = 1'b1;
						end else if (pw_cmd(I_CMD_OPCODE)) begin
							// (R2) (R16) (R17) reject before sector
							if (frozen_reg || attempts_reg == 3'h0
								|| (I_CMD_OPCODE == OP_SET_PW && locked_reg)
								|| (I_CMD_OPCODE == OP_ERASE_UNIT && !prepared_reg)) begin
								abt_next = 1'b1;
							end else begin
								// (R6) one sector expected
								state_next = CMD_RECV;
								rx_start   = 1'b1;
							end
						end else if (I_CMD_OPCODE != OP_ERASE_PREP) begin
							abt_next = 1'b1;
						end
					end
				end
				CMD_RECV: begin
					if (rx_done) begin
						state_next = CMD_EXEC;
					end
				end
				CMD_EXEC: begin
					state_next = CMD_IDLE;
					unique case (op_reg)
						OP_SET_PW: begin
							if (master_sel) begin
								// (R5) master stored, lock untouched
								master_pw_next = rx_pw;
								// (R9) revision kept on 0000h or FFFFh
								if (rx_rev != REV_KEEP_LO && rx_rev != REV_KEEP_HI) begin
									rev_next = rx_rev;
								end
							end else begin
								// (R4) (R10) (R11) arm, stay unlocked
								user_pw_next   = rx_pw;
								level_max_next = rx_ctl[CTL_LEVEL_BIT];
								armed_next     = 1'b1;
							end
						end
						OP_UNLOCK: begin
							if (master_refused) begin
								// (R14) master refused
								abt_next = 1'b1;
							end else if (pw_match) begin
								// (R13) unlocked, passwords kept
								locked_next = 1'b0;
							end else begin
								// (R16) count the miss
								abt_next      = 1'b1;
								attempts_next = attempts_reg - 3'h1;
							end
						end
						OP_DISABLE_PW: begin
							if (!master_refused && pw_match) begin
								armed_next  = 1'b0;
								locked_next = 1'b0;
							end else begin
								abt_next = 1'b1;
							end
						end
						OP_ERASE_UNIT: begin
							// (R12) erase clears lock at any level
							if (pw_match) begin
								armed_next  = 1'b0;
								locked_next = 1'b0;
								erase_next  = 1'b1;
							end else begin
								abt_next = 1'b1;
							end
						end
						default: begin
							abt_next = 1'b1;
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			hr_sync_reg   <= 3'h7;
			hr_active_reg <= 1'b0;
			state_reg     <= CMD_IDLE;
			op_reg        <= 8'h00;
			abt_reg       <= 1'b0;
			frozen_reg    <= 1'b0;
			armed_reg     <= 1'b0;
			locked_reg    <= 1'b0;
			level_max_reg <= 1'b0;
			prepared_reg  <= 1'b0;
			erase_reg     <= 1'b0;
			attempts_reg  <= ATTEMPTS_INIT;
			rev_reg       <= REV_INIT;
			user_pw_reg   <= '0;
			master_pw_reg <= '0;
		end else begin
			hr_sync_reg   <= hr_sync_next;
			hr_active_reg <= hr_active_next;
			state_reg     <= state_next;
			op_reg        <= op_next;
			abt_reg       <= abt_next;
			frozen_reg    <= frozen_next;
			armed_reg     <= armed_next;
			locked_reg    <= locked_next;
			level_max_reg <= level_max_next;
			prepared_reg  <= prepared_next;
			erase_reg     <= erase_next;
			attempts_reg  <= attempts_next;
			rev_reg       <= rev_next;
			user_pw_reg   <= user_pw_next;
			master_pw_reg <= master_pw_next;
		end
	end

	always_comb begin
		O_STATUS              = 8'h00;
		O_STATUS[ST_BSY_BIT]  = state_reg == CMD_EXEC;
		O_STATUS[ST_RDY_BIT]  = 1'b1;
		O_STATUS[ST_DSC_BIT]  = 1'b1;
		O_STATUS[ST_DRQ_BIT]  = state_reg == CMD_RECV;
		O_STATUS[ST_ERR_BIT]  = abt_reg;
		O_ERROR               = 8'h00;
		O_ERROR[ERR_ABT_BIT]  = abt_reg;
	end

	assign O_REV_CODE    = rev_reg;
	assign O_FROZEN      = frozen_reg;
	assign O_LOCKED      = locked_reg;
	assign O_LOCK_ARMED  = armed_reg;
	assign O_LEVEL_MAX   = level_max_reg;
	assign O_ATTEMPTS    = attempts_reg;
	assign O_ERASE_START = erase_reg;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	sequence s_exec(logic [7:0] op);
		state_reg == CMD_EXEC && op_reg == op && !hr_active_reg && !I_SOFT_RST;
	endsequence
	property p_freeze;
		take_ok && I_CMD_OPCODE == OP_FREEZE |=> frozen_reg && !abt_reg && !O_STATUS[ST_DRQ_BIT];
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze not immediate"); // (R1)
	property p_frozen_reject;
		take_ok && frozen_reg && pw_cmd(I_CMD_OPCODE) |=> abt_reg && state_reg == CMD_IDLE;
	endproperty
	a_frozen_reject: assert property (p_frozen_reject) else $error("frozen cmd accepted"); // (R2)
	property p_frozen_keep;
		frozen_reg |=> frozen_reg;
	endproperty
	a_frozen_keep: assert property (p_frozen_keep) else $error("frozen state lost"); // (R3)
	property p_user_arm;
		s_exec(OP_SET_PW) ##0 !master_sel |=> armed_reg && locked_reg == $past(locked_reg)
			&& user_pw_reg == $past(rx_pw);
	endproperty
	a_user_arm: assert property (p_user_arm) else $error("user set did not arm"); // (R4)
	property p_master_noarm;
		s_exec(OP_SET_PW) ##0 master_sel |=> armed_reg == $past(armed_reg)
			&& master_pw_reg == $past(rx_pw);
	endproperty
	a_master_noarm: assert property (p_master_noarm) else $error("master set armed"); // (R5)
	sequence s_sector_end;
		state_reg == CMD_RECV && rx_done && !hr_active_reg && !I_SOFT_RST;
	endsequence
	property p_sector;
		s_sector_end |=> state_reg == CMD_EXEC ##1 state_reg == CMD_IDLE;
	endproperty
	a_sector: assert property (p_sector) else $error("sector end not executed"); // (R6)
	property p_rev;
		s_exec(OP_SET_PW) ##0 master_sel |=> rev_reg == (($past(rx_rev) == REV_KEEP_LO
			|| $past(rx_rev) == REV_KEEP_HI) ? $past(rev_reg) : $past(rx_rev));
	endproperty
	a_rev: assert property (p_rev) else $error("revision code wrong"); // (R9)
	property p_unlock_ok;
		s_exec(OP_UNLOCK) ##0 (!master_refused && pw_match) |=> !locked_reg && !abt_reg
			&& user_pw_reg == $past(user_pw_reg);
	endproperty
	a_unlock_ok: assert property (p_unlock_ok) else $error("good unlock failed"); // (R13)
	property p_max_master;
		s_exec(OP_UNLOCK) ##0 master_refused |=> abt_reg && locked_reg == $past(locked_reg);
	endproperty
	a_max_master: assert property (p_max_master) else $error("master unlock at max"); // (R14)
	property p_fail_count;
		s_exec(OP_UNLOCK) ##0 (!master_refused && !pw_match) |=> abt_reg
			&& attempts_reg == $past(attempts_reg) - 3'h1;
	endproperty
	a_fail_count: assert property (p_fail_count) else $error("miss not counted"); // (R16)
	property p_zero_reject;
		take_ok && attempts_reg == 3'h0 && pw_cmd(I_CMD_OPCODE) |=> abt_reg && state_reg == CMD_IDLE;
	endproperty
	a_zero_reject: assert property (p_zero_reject) else $error("cmd at zero count"); // (R17)
	property p_hard;
		hr_active_reg |=> attempts_reg == ATTEMPTS_INIT && locked_reg == armed_reg;
	endproperty
	a_hard: assert property (p_hard) else $error("hard reset restore wrong"); // (R18)
endmodule // dsl_lock_top

// ===== sim/dsl_host_model.sv
`timescale 1ns/100ps
module dsl_host_model (
	input  wire logic                          i_clk,
	input  wire logic [7:0]                    i_status,
	output logic                               o_cmd_wr,
	output logic      [dsl_pkg::OPCODE_W-1:0]  o_opcode,
	output logic                               o_data_wr,
	output logic      [dsl_pkg::WORD_W-1:0]    o_data
);
	import dsl_pkg::*;
	int hang_cnt = 0;
	initial begin
		o_cmd_wr  = 1'b0;
		o_opcode  = 8'h00;
		o_data_wr = 1'b0;
		o_data    = 16'h0000;
	end
	// Sends the sector only when the device asks for it, so early refusals stay visible.
	task automatic run_cmd(input logic [7:0] op, input logic [15:0] ctl,
		input logic [255:0] pw, input logic [15:0] rev, output logic drq);
		logic [15:0] w;
		int          n;
		@(posedge i_clk);
		o_cmd_wr <= 1'b1;
		o_opcode <= op;
		@(posedge i_clk);
		o_cmd_wr <= 1'b0;
		#1;
		drq = i_status[ST_DRQ_BIT];
		if (drq === 1'b1) begin
			for (int i = 0; i < 256; i++) begin
				w = (i == 0) ? ctl : (i <= 16) ? pw[16*(i-1) +: 16] : (i == 17) ? rev : ~i[15:0];
				@(posedge i_clk);
				o_data_wr <= 1'b1;
				o_data    <= w;
			end
			@(posedge i_clk);
			o_data_wr <= 1'b0;
			o_data    <= ~w;
		end
		n = 0;
		while (n < 40 && (i_status[ST_BSY_BIT] !== 1'b0 || i_status[ST_DRQ_BIT] !== 1'b0)) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 40) begin
			hang_cnt++;
		end
	endtask
endmodule // dsl_host_model

// ===== sim/tb_drive_security_lock_commands.sv
`timescale 1ns/100ps
module tb_drive_security_lock_commands;
	import dsl_pkg::*;
	typedef struct {
		logic [7:0]   op;
		logic [15:0]  ctl;
		logic [255:0] pw;
		logic [15:0]  rev;
		logic         drq;
		logic         abt;
		logic         armed;
		logic [15:0]  rev_out;
	} dsl_row_type;
	localparam logic [255:0] PW_A = {16{16'h1234}};
	localparam logic [255:0] PW_B = {16{16'hBEEF}};
	logic        clk, rst, hard_rst_n, soft_rst, cmd_wr, data_wr, drq;
	logic [7:0]  opcode, err_reg, status;
	logic [15:0] data, rev_code;
	logic        frozen, locked, armed, lmax, erase_start;
	logic [2:0]  attempts;
	int          err_total = 0;
	int          tests_run = 0;
	dsl_row_type rows [7];
	logic [7:0]  fz_ops [4] = '{OP_SET_PW, OP_UNLOCK, OP_DISABLE_PW, OP_ERASE_UNIT};

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	dsl_lock_top uut (.I_CLK(clk), .I_RST(rst), .I_HARD_RST_N(hard_rst_n), .I_SOFT_RST(soft_rst),
		.I_CMD_WR(cmd_wr), .I_CMD_OPCODE(opcode), .I_DATA_WR(data_wr), .I_DATA(data),
		.O_ERROR(err_reg), .O_STATUS(status), .O_REV_CODE(rev_code), .O_FROZEN(frozen),
		.O_LOCKED(locked), .O_LOCK_ARMED(armed), .O_LEVEL_MAX(lmax), .O_ATTEMPTS(attempts),
		.O_ERASE_START(erase_start));

	dsl_host_model host (.i_clk(clk), .i_status(status), .o_cmd_wr(cmd_wr), .o_opcode(opcode),
		.o_data_wr(data_wr), .o_data(data));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic expect_st(input logic e_drq, e_abt, e_locked, input logic [2:0] e_att);
		check("drq_raised", drq, e_drq);
		check("abort_flag", err_reg[ERR_ABT_BIT], e_abt);
		check("status_err", status[ST_ERR_BIT], e_abt);
		check("locked", locked, e_locked);
		check("attempts", attempts, e_att);
	endtask

	task automatic hard_reset;
		@(posedge clk);
		hard_rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		hard_rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic unlock(input logic [15:0] ctl, input logic [255:0] pw);
		host.run_cmd(OP_UNLOCK, ctl, pw, 16'h0000, drq);
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		rst        = 1'b1;
		hard_rst_n = 1'b1;
		soft_rst   = 1'b0;
		rows = '{
			'{OP_SET_PW, 16'h0101, PW_B, 16'h0001, 1'b1, 1'b0, 1'b0, 16'h0001},
			'{OP_SET_PW, 16'h0001, PW_B, 16'hFFFF, 1'b1, 1'b0, 1'b0, 16'h0001},
			'{OP_SET_PW, 16'h0001, PW_B, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0001},
			'{OP_SET_PW, 16'h0001, PW_B, 16'hFFFE, 1'b1, 1'b0, 1'b0, 16'hFFFE},
			'{OP_SET_PW, 16'h0001, PW_B, 16'h0002, 1'b1, 1'b0, 1'b0, 16'h0002},
			'{8'h00,     16'h0000, PW_A, 16'h0000, 1'b0, 1'b1, 1'b0, 16'h0002},
			'{OP_SET_PW, 16'h0000, PW_A, 16'h0000, 1'b1, 1'b0, 1'b1, 16'h0002}};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("status_reset", status, 8'h50);
		check("error_reset", err_reg, 8'h00);
		check("attempts_reset", attempts, 3'h5);
		for (int r = 0; r < 7; r++) begin
			host.run_cmd(rows[r].op, rows[r].ctl, rows[r].pw, rows[r].rev, drq);
			check("row_drq", drq, rows[r].drq);
			check("row_abort", err_reg[ERR_ABT_BIT], rows[r].abt);
			check("row_armed", armed, rows[r].armed);
			check("row_locked", locked, 1'b0);
			check("row_rev", rev_code, rows[r].rev_out);
		end
		hard_reset();
		check("locked_after_hard", locked, 1'b1);
		unlock(16'h0000, PW_A ^ {1'b1, 255'h0});
		expect_st(1'b1, 1'b1, 1'b1, 3'h4);
		unlock(16'h0000, PW_A ^ 256'h1);
		expect_st(1'b1, 1'b1, 1'b1, 3'h3);
		unlock(16'h0001, PW_B);
		expect_st(1'b1, 1'b0, 1'b0, 3'h3);
		check("armed_kept", armed, 1'b1);
		hard_reset();
		check("relocked", locked, 1'b1);
		check("attempts_restored", attempts, 3'h5);
		unlock(16'h0000, PW_A);
		expect_st(1'b1, 1'b0, 1'b0, 3'h5);
		host.run_cmd(OP_SET_PW, 16'h0100, PW_A, 16'h0000, drq);
		check("level_max", lmax, 1'b1);
		hard_reset();
		unlock(16'h0001, PW_B);
		expect_st(1'b1, 1'b1, 1'b1, 3'h5);
		repeat (5) unlock(16'h0000, PW_B);
		expect_st(1'b1, 1'b1, 1'b1, 3'h0);
		unlock(16'h0000, PW_A);
		expect_st(1'b0, 1'b1, 1'b1, 3'h0);
		hard_reset();
		unlock(16'h0000, PW_A);
		expect_st(1'b1, 1'b0, 1'b0, 3'h5);
		hard_reset();
		host.run_cmd(OP_ERASE_UNIT, 16'h0001, PW_B, 16'h0000, drq);
		expect_st(1'b0, 1'b1, 1'b1, 3'h5);
		host.run_cmd(OP_ERASE_PREP, 16'h0000, PW_A, 16'h0000, drq);
		expect_st(1'b0, 1'b0, 1'b1, 3'h5);
		host.run_cmd(OP_ERASE_UNIT, 16'h0001, PW_A, 16'h0000, drq);
		expect_st(1'b1, 1'b1, 1'b1, 3'h5);
		check("erase_refused", erase_start, 1'b0);
		host.run_cmd(OP_ERASE_PREP, 16'h0000, PW_A, 16'h0000, drq);
		host.run_cmd(OP_ERASE_UNIT, 16'h0001, PW_B, 16'h0000, drq);
		expect_st(1'b1, 1'b0, 1'b0, 3'h5);
		check("erase_pulse", erase_start, 1'b1);
		check("erase_disarms", armed, 1'b0);
		@(posedge clk);
		#1;
		check("erase_pulse_end", erase_start, 1'b0);
		hard_reset();
		check("no_relock_unarmed", locked, 1'b0);
		host.run_cmd(OP_SET_PW, 16'h0000, PW_B, 16'h0000, drq);
		check("rearmed", armed, 1'b1);
		check("level_high", lmax, 1'b0);
		host.run_cmd(OP_DISABLE_PW, 16'h0000, PW_A, 16'h0000, drq);
		expect_st(1'b1, 1'b1, 1'b0, 3'h5);
		host.run_cmd(OP_DISABLE_PW, 16'h0000, PW_B, 16'h0000, drq);
		expect_st(1'b1, 1'b0, 1'b0, 3'h5);
		check("disable_disarms", armed, 1'b0);
		hard_reset();
		check("disabled_no_relock", locked, 1'b0);
		host.run_cmd(OP_FREEZE, 16'h0000, PW_A, 16'h0000, drq);
		check("freeze_drq", drq, 1'b0);
		check("freeze_abort", err_reg[ERR_ABT_BIT], 1'b0);
		check("frozen", frozen, 1'b1);
		foreach (fz_ops[k]) begin
			host.run_cmd(fz_ops[k], 16'h0000, PW_A, 16'h0000, drq);
			check("frozen_drq", drq, 1'b0);
			check("frozen_abort", err_reg[ERR_ABT_BIT], 1'b1);
		end
		@(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		#1;
		check("soft_clears_abort", err_reg[ERR_ABT_BIT], 1'b0);
		check("soft_keeps_frozen", frozen, 1'b1);
		hard_reset();
		check("frozen_kept", frozen, 1'b1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("frozen_cleared", frozen, 1'b0);
		check("host_no_hang", host.hang_cnt, 32'h0);
		tally_and_finish();
	end
endmodule // tb_drive_security_lock_commands
